/* File: reset_seq_defines.vh */
// constants for the system reset sequencer
// assumes a 50 MHz core clock; fuse inputs are static straps
`ifndef RESET_SEQ_DEFINES_VH
`define RESET_SEQ_DEFINES_VH
// ==================================================
// timing
`define CLK_PERIOD_NS 20
`define PIN_MIN_PULSE_NS 50
`define PIN_MIN_CYCLES ((`PIN_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BROWNOUT_FILTER_US 2
`define BROWNOUT_FILTER_CYCLES ((`BROWNOUT_FILTER_US * 1000) / `CLK_PERIOD_NS)
`define TIMER_W 20
`define FILT_W 8
// ==================================================
// start-up timeout per clock select setting, in cycles
`define TOUT_SEL0 20'h0_0001
`define TOUT_SEL1 20'h0_0040
`define TOUT_SEL2 20'h0_0400
`define TOUT_SEL3 20'h0_4000
`define TOUT_SELX 20'hF_FFFF
// ==================================================
// cause flag bit positions
`define FLAG_PWR 0
`define FLAG_PIN 1
`define FLAG_BOD 2
`define FLAG_WDG 3
`define FLAG_W 4
// ==================================================
// states
`define ST_HOLD 2'h0
`define ST_STRETCH 2'h1
`define ST_RUN 2'h2
`endif

/* File: system_reset_sequencer.v */
// system reset sequencer: merges the reset sources into one internal reset
// assumes detector and pin inputs are asynchronous and fuses are static
// How it works
// - internal reset holds I/O registers at initial value; release fetches reset vector
// - power-on or pin source, or any qualified request, forces the port reset output from a flop after the synchronisers
// - after all sources inactive, delay counter stretches the internal reset
// - stretch length chosen by clock select fuses
// - four sources: power-on, reset pin, watchdog, brown-out, one reset
// - pin low longer than minimum pulse resets; driver must hold it that long
// - pin rising starts delay counter; release after start-up timeout
// - watchdog expiry resets only while watchdog enabled
// - power-on threshold crossing starts the delay counter
// - supply falling below power-on level reasserts reset three cycles later, through the synchronisers
// - brown-out detector contributes nothing unless its enable fuse is set
// - enabled brown-out with low supply asserts reset once the filter time has passed
// - supply back above brown-out level starts delay counter
// - level fuse picks higher trigger when programmed, lower otherwise
// - brown-out only counts if undervoltage stays longer than filter time
// - watchdog gives one-cycle reset pulse; delay starts on its fall
// - watchdog, brown-out, pin flags sticky; cleared by power-on or write zero
// - power-on flag set on power-on, cleared only by write zero
`include "reset_seq_defines.vh"

module system_reset_sequencer (
  // clock and reset
  input wire i_core_clk,
  input wire i_resetn,
  // reset sources
  input wire i_power_low,
  input wire i_pin_resetn,
  input wire i_watchdog_expire,
  input wire i_watchdog_enable,
  input wire i_below_high_level,
  input wire i_below_low_level,
  // fuses
  input wire [1:0] i_clock_select_fuses,
  input wire i_brownout_enable_fuse,
  input wire i_brownout_level_fuse,
  // cause flag software write
  input wire i_flag_wr,
  input wire [`FLAG_W-1:0] i_flag_wdata,
  // outputs
  output reg o_internal_reset,
  output reg o_port_reset,
  output reg o_fetch_vector,
  output reg [`FLAG_W-1:0] o_cause_flags
);

// ==================================================
// synchronisers
reg pwr_s1_r, pwr_s2_r;
reg pin_s1_r, pin_s2_r;
reg wdg_s1_r, wdg_s2_r;
reg hi_s1_r, hi_s2_r;
reg lo_s1_r, lo_s2_r;

always @(posedge i_core_clk) begin
  pwr_s1_r <= i_power_low;
  pwr_s2_r <= pwr_s1_r;
  pin_s1_r <= ~i_pin_resetn;
  pin_s2_r <= pin_s1_r;
  wdg_s1_r <= i_watchdog_expire;
  wdg_s2_r <= wdg_s1_r;
  hi_s1_r <= i_below_high_level;
  hi_s2_r <= hi_s1_r;
  lo_s1_r <= i_below_low_level;
  lo_s2_r <= lo_s1_r;
end

// ==================================================
// source qualification
// pin needs the minimum pulse before it counts; short glitches fall away
reg [`FILT_W-1:0] pin_cnt_r;
reg [`FILT_W-1:0] bod_cnt_r;
reg pin_req_r, bod_req_r, wdg_prev_r, wdg_pulse_r;
wire bod_low;
wire pin_done;
wire bod_done;

assign bod_low = i_brownout_enable_fuse &
  (i_brownout_level_fuse ? hi_s2_r : lo_s2_r);
assign pin_done = (pin_cnt_r >= `PIN_MIN_CYCLES - 1);
assign bod_done = (bod_cnt_r >= `BROWNOUT_FILTER_CYCLES);

always @(posedge i_core_clk) begin
  if (!i_resetn) begin
    pin_cnt_r <= {`FILT_W{1'b0}};
    bod_cnt_r <= {`FILT_W{1'b0}};
    pin_req_r <= 1'b0;
    bod_req_r <= 1'b0;
    wdg_prev_r <= 1'b0;
    wdg_pulse_r <= 1'b0;
  end else begin
    if (!pin_s2_r) begin
      pin_cnt_r <= {`FILT_W{1'b0}};
      pin_req_r <= 1'b0;
    end else if (!pin_done) begin
      pin_cnt_r <= pin_cnt_r + 1'b1;
    end else begin
      pin_req_r <= 1'b1;
    end
    if (!bod_low) begin
      bod_cnt_r <= {`FILT_W{1'b0}};
      bod_req_r <= 1'b0;
    end else if (!bod_done) begin
      bod_cnt_r <= bod_cnt_r + 1'b1;
    end else begin
      bod_req_r <= 1'b1;
    end
    wdg_prev_r <= wdg_s2_r;
    // one-cycle pulse on expiry edge, gated by enable
    wdg_pulse_r <= wdg_s2_r & ~wdg_prev_r & i_watchdog_enable;
  end
end

// ==================================================
// combined request and stretch counter
wire any_req;
assign any_req = pwr_s2_r | pin_req_r | bod_req_r | wdg_pulse_r;

// the selected timeout is re-read every cycle; fuses are assumed static
reg [`TIMER_W-1:0] tout_sel;
always @* begin
  case (i_clock_select_fuses)
    2'h0: tout_sel = `TOUT_SEL0;
    2'h1: tout_sel = `TOUT_SEL1;
    2'h2: tout_sel = `TOUT_SEL2;
    2'h3: tout_sel = `TOUT_SEL3;
    default: tout_sel = `TOUT_SELX;
  endcase
end

// hold while any request stands, stretch counts, run lets the core go;
// a request in any state sends the machine back to hold
reg [1:0] state_r;
reg [`TIMER_W-1:0] timer_r;

always @(posedge i_core_clk) begin
  if (!i_resetn) begin
    state_r <= `ST_HOLD;
    timer_r <= {`TIMER_W{1'b0}};
  end else begin
    case (state_r)
      `ST_HOLD: begin
        timer_r <= {`TIMER_W{1'b0}};
        if (!any_req) begin
          state_r <= `ST_STRETCH;
        end
      end
      `ST_STRETCH: begin
        if (any_req) begin
          state_r <= `ST_HOLD;
        end else if (timer_r >= tout_sel - 1'b1) begin
          state_r <= `ST_RUN;
        end else begin
          timer_r <= timer_r + 1'b1;
        end
      end
      `ST_RUN: begin
        if (any_req) begin
          state_r <= `ST_HOLD;
        end
      end
      default: state_r <= `ST_HOLD;
    endcase
  end
end

// ==================================================
// outputs and cause flags
// port reset is a flop behind the synchronisers, so it follows the raw sources three cycles late;
// truly clockless forcing lives in the pad ring outside this block

// release only from run with nothing pending; a request landing in the
// first run cycle keeps reset up and must not leave a stray fetch behind
wire release_ok;
assign release_ok = (state_r == `ST_RUN) & ~any_req;

always @(posedge i_core_clk) begin
  if (!i_resetn) begin
    o_internal_reset <= 1'b1;
    o_port_reset <= 1'b1;
    o_fetch_vector <= 1'b0;
  end else begin
    o_internal_reset <= ~release_ok;
    o_port_reset <= any_req | pwr_s2_r | pin_s2_r;
    // fetch marks the very edge on which the reset really drops
    o_fetch_vector <= release_ok & o_internal_reset;
  end
end

reg [`FLAG_W-1:0] flags_nxt;
always @* begin
  flags_nxt = o_cause_flags;
  if (i_flag_wr) begin
    flags_nxt = o_cause_flags & i_flag_wdata;
  end
  if (pwr_s2_r) begin
    // power-on clears the other causes
    flags_nxt = {`FLAG_W{1'b0}};
    flags_nxt[`FLAG_PWR] = 1'b1;
  end
  // sets win over a simultaneous software clear
  if (pin_req_r) begin
    flags_nxt[`FLAG_PIN] = 1'b1;
  end
  if (bod_req_r) begin
    flags_nxt[`FLAG_BOD] = 1'b1;
  end
  if (wdg_pulse_r) begin
    flags_nxt[`FLAG_WDG] = 1'b1;
  end
end

always @(posedge i_core_clk) begin
  if (!i_resetn) begin
    o_cause_flags <= {`FLAG_W{1'b0}};
  end else begin
    o_cause_flags <= flags_nxt;
  end
end

endmodule // system_reset_sequencer

/* File: system_reset_sequencer_properties.sv */
// port assertions for the reset sequencer
// assumes bind into every sequencer instance
module reset_seq_checker (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_power_low,
  input wire i_pin_resetn,
  input wire i_flag_wr,
  input wire o_internal_reset,
  input wire o_port_reset,
  input wire o_fetch_vector,
  input wire [3:0] o_cause_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // ==========
  // release and hold
  property p_fetch_once; o_fetch_vector |=> !o_fetch_vector; endproperty
  a_fetch_once: assert property (p_fetch_once) else $error("fetch");
  property p_free; o_fetch_vector |-> !o_internal_reset; endproperty
  a_free: assert property (p_free) else $error("release");
  property p_fell; $fell(o_internal_reset) |-> o_fetch_vector; endproperty
  a_fell: assert property (p_fell) else $error("early release");
  property p_pwr_port; i_power_low |-> ##[1:3] o_port_reset; endproperty
  a_pwr_port: assert property (p_pwr_port) else $error("port power");
  property p_pin_port; !i_pin_resetn |-> ##[1:3] o_port_reset; endproperty
  a_pin_port: assert property (p_pin_port) else $error("port pin");
  property p_pwr_hold; i_power_low [*4] |-> o_internal_reset; endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("power hold");
  property p_pin_hold; !i_pin_resetn [*8] |-> o_internal_reset; endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin hold");
  property p_pwr_flag; i_power_low [*6] |-> o_cause_flags[0]; endproperty
  a_pwr_flag: assert property (p_pwr_flag) else $error("power flag");
  property p_pwr_keep;
    $fell(o_cause_flags[0]) |-> $past(i_flag_wr);
  endproperty
  a_pwr_keep: assert property (p_pwr_keep) else $error("power lost");
endmodule // reset_seq_checker
bind system_reset_sequencer reset_seq_checker u_chk (.*);

/* File: reset_source_model.sv */
// far side: supply monitors, reset pin driver, watchdog
// assumes the bench picks one source at a time
module reset_source_model (
  input wire [2:0] i_sel,
  input wire i_act,
  output wire [4:0] o_src
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // bit 1 is the pin, idle high by its pull-up
  assign o_src = (i_act ? 5'h01 << i_sel : 5'h00) ^ 5'h02;
endmodule // reset_source_model

/* File: system_reset_sequencer_tb.sv */
// bench for the reset sequencer
// assumes the checker is bound in from its own file
module system_reset_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, act, wen, ben, lvl, fwr;
  logic [2:0] sel;
  logic [3:0] wd;
  logic [1:0] cks;
  wire [4:0] src;
  wire ir, pr, fv;
  wire [3:0] fl;
  int fails, cmp_count, hi, nf, k, tn;
  reset_source_model i_model (.i_sel(sel), .i_act(act), .o_src(src));
  system_reset_sequencer i_dut (.i_core_clk(clk), .i_resetn(rstn),
    .i_power_low(src[0]), .i_pin_resetn(src[1]), .i_watchdog_expire(src[4]),
    .i_watchdog_enable(wen), .i_below_high_level(src[2]),
    .i_below_low_level(src[3]), .i_clock_select_fuses(cks),
    .i_brownout_enable_fuse(ben), .i_brownout_level_fuse(lvl),
    .i_flag_wr(fwr), .i_flag_wdata(wd), .o_internal_reset(ir),
    .o_port_reset(pr), .o_fetch_vector(fv), .o_cause_flags(fl));
  // ==========
  // clock, compare, closing
  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  task automatic chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // software write of the cause flags, strobe held one full cycle
  task automatic wr(input [3:0] d);
    fwr = 1'b1;
    wd = d;
    @(negedge clk);
    fwr = 1'b0;
    @(negedge clk);
  endtask
  // source s for n cycles; a short window catches the watchdog pulse
  task automatic go(input [2:0] s, input int n, input e, input [3:0] f);
    sel = s;
    act = 1'b1;
    repeat (n) @(negedge clk);
    act = 1'b0;
    hi = 0;
    nf = 0;
    for (k = 0; k < 1500 && (k < 12 || ir === 1'b1); k++) begin
      @(negedge clk);
      hi += (ir === 1'b1);
      nf += (fv === 1'b1);
    end
    tn++;
    chk("reset", hi != 0, e);
    chk("fetch", nf, e);
    chk("flags", fl, f);
    $display("test %0d done", tn);
  endtask
  initial begin
    {act, wen, ben, fwr, sel, cks} = 9'h000;
    wd = 4'h0;
    lvl = 1'b1;
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    go(3'h0, 10, 1'b1, 4'h1);
    go(3'h1, 8, 1'b1, 4'h3);
    go(3'h1, 1, 1'b0, 4'h3);
    go(3'h4, 2, 1'b0, 4'h3);
    wen = 1'b1;
    go(3'h4, 2, 1'b1, 4'hb);
    go(3'h2, 120, 1'b0, 4'hb);
    ben = 1'b1;
    go(3'h3, 120, 1'b0, 4'hb);
    go(3'h2, 50, 1'b0, 4'hb);
    go(3'h2, 120, 1'b1, 4'hf);
    lvl = 1'b0;
    go(3'h3, 120, 1'b1, 4'hf);
    wr(4'h5);
    chk("keep", fl, 4'h5);
    go(3'h0, 10, 1'b1, 4'h1);
    wr(4'h0);
    chk("clear", fl, 4'h0);
    cks = 2'h1;
    go(3'h1, 8, 1'b1, 4'h2);
    chk("stretch", hi >= 64 && hi <= 76, 1'b1);
    report_and_stop;
  end
  // the whole sequence needs about 800 cycles
  initial begin
    #200000;
    fails++;
    report_and_stop;
  end
endmodule // system_reset_sequencer_tb
